// [design/ppc_pkg.sv]
// Constants, types and carriers for port power and Type-C attach control.
// Assumes one 10 MHz clock and synchronous pin and comparator inputs.
// Summary of operation
// - One shared pin per port: power and sense.
// - Power off drives the shared pin low.
// - Pull-up is off while pin driven low.
// - Power on releases driver, enables pull-up.
// - Low on enabled pin means over-current.
// - Over-current sense is filtered against transients.
// - Power driven by hub logic or processor.
// - Per-port charger-present indication is configurable.
// - PD messages buffered for firmware both ways.
// - Recognise PD class and vendor register requests.
// - CC comparator scans eight DAC thresholds.
// - Sink reports changes in advertised current.
// - Source sees Rd attach and Ra cable.
// - Sink applies Rd, waits for VBUS, classifies.
// - Active cable enables VCONN on other line.
// - Low VCONN voltage on CC flags over-current.
// - Sink attach/detach follows VBUS range comparator.
// - Source confirms VBUS reached the safe 5 V range.
package ppc_pkg;
   // Port count and clock rate.
   localparam int NPORT = 4;
   localparam int CLK_MHZ = 10;
   // Over-current filter time and its cycle count.
   localparam int OC_FILT_US = 100;
   localparam int OC_FILT_CYC = OC_FILT_US * CLK_MHZ;
   // Comparator settle time per DAC step, rounded up to cycles.
   localparam int SETTLE_NS = 1000;
   localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   // Filter counter width.
   localparam int FW = 12;
   localparam logic [FW-1:0] OC_LIMIT = FW'(OC_FILT_CYC);
   // DAC threshold codes and nominal levels in millivolts.
   localparam int NTHR = 8;
   localparam int DW = 3;
   localparam int THR_MV [7] = '{200, 400, 660, 800, 1230, 1600, 2600};
   localparam logic [DW-1:0] DAC_LAST = 3'h7;
   // CC level is the count of thresholds exceeded.
   localparam int LW = 4;
   localparam logic [LW-1:0] LVL_RA_MAX = 4'h0;
   localparam logic [LW-1:0] LVL_OPEN = 4'h7;
   localparam logic [LW-1:0] LVL_DEF_MAX = 4'h2;
   localparam logic [LW-1:0] LVL_1A5_MAX = 4'h4;
   localparam logic [LW-1:0] LVL_VCONN_MIN = 4'h7;
   localparam logic [LW-1:0] LVL_ALL = 4'h8;
   // PD message buffer depth.
   localparam int BDEPTH = 16;
   localparam int AW = 4;
   // Request codes in the first message byte; values are arbitrary.
   localparam logic [7:0] RC_BATT = 8'h01;
   localparam logic [7:0] RC_FEAT = 8'h02;
   localparam logic [7:0] RC_WREG = 8'h10;
   localparam logic [7:0] RC_RREG = 8'h11;
   localparam logic [7:0] RC_WMEM = 8'h12;
   localparam logic [7:0] RC_RMEM = 8'h13;

   // Advertised source current.
   typedef enum logic [1:0] {ADV_DEF, ADV_1A5, ADV_3A0, ADV_NONE} ppc_adv_t;
   // Kind of the buffered request.
   typedef enum logic [2:0] {
      RQ_NONE, RQ_BATT, RQ_FEAT, RQ_WREG, RQ_RREG, RQ_WMEM, RQ_RMEM, RQ_OTHER
   } ppc_req_t;
   // Attach state.
   typedef enum logic [1:0] {ST_UNATT, ST_PEND, ST_ATT} ppc_att_t;

   // Type-C status carrier.
   typedef struct packed {
      logic attached;
      logic pending;
      logic dfp;
      logic orient_cc2;
      logic active_cable;
      ppc_adv_t adv;
      logic vbus_ok;
   } ppc_tc_stat_t;

   // Type-C pin control carrier.
   typedef struct packed {
      logic rp_en;
      logic rd_en;
      logic [DW-1:0] dac_code;
      logic [1:0] vconn_en;
   } ppc_tc_pins_t;
endpackage

// [design/ppc_filt.sv]
// Digital glitch filter for one level input.
// Assumes the input is synchronous to mclk.
`timescale 1ns/1ps
module ppc_filt import ppc_pkg::*; (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Raw level and number of samples needed to change state.
   input wire logic d,
   input wire logic [FW-1:0] limit,
   // Filtered level.
   output logic q
);
   // Consecutive samples that disagree with the output.
   logic [FW-1:0] cnt_r;
   // Count reaches the limit; a limit of zero acts as one.
   wire logic flip = (d != q) && ((cnt_r + FW'(1)) >= limit);

   // The output changes only after limit disagreeing samples in a row.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
         q <= 1'b0;
      end else if (d == q || flip) begin
         cnt_r <= '0;
         q <= flip ? d : q;
      end else begin
         cnt_r <= cnt_r + FW'(1);
      end
   end
endmodule

// [design/ppc_port_ctrl.sv]
// Downstream port power control, Type-C attach logic and PD buffers.
// Assumes all pins and comparator outputs are synchronous to mclk.
`timescale 1ns/1ps
module ppc_port_ctrl import ppc_pkg::*; (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Port power requests and configuration.
   input wire logic cpu_mode,
   input wire logic [NPORT-1:0] hub_pwr_req,
   input wire logic [NPORT-1:0] cpu_pwr_req,
   input wire logic [NPORT-1:0] bc_cfg,
   input wire logic [NPORT-1:0] oc_clr,
   // Shared power control and over-current sense pins.
   input wire logic [NPORT-1:0] port_power_sense_pin_i,
   output logic [NPORT-1:0] port_power_sense_pin_o,
   output logic [NPORT-1:0] port_power_sense_pin_oe_n,
   output logic [NPORT-1:0] pin_pullup_en,
   output logic [NPORT-1:0] programmable_function_pin,
   // Port power status.
   output logic [NPORT-1:0] port_pwr_on,
   output logic [NPORT-1:0] oc_flag,
   // Type-C role, comparators and configuration.
   input wire logic role_dfp,
   input wire logic cc1_cmp,
   input wire logic cc2_cmp,
   input wire logic vbus_monitor_safe5v,
   input wire logic vbus_monitor_safe0v,
   input wire logic [FW-1:0] attach_dbnc,
   input wire logic vconn_dis,
   input wire logic vconn_oc_clr,
   // Type-C outputs.
   output ppc_tc_pins_t tc_pins,
   output ppc_tc_stat_t tc_stat,
   output logic adv_change,
   output logic vconn_oc,
   // PD receive path from the host side.
   input wire logic pd_rx_valid,
   input wire logic [7:0] pd_rx_byte,
   input wire logic pd_rx_last,
   output logic pd_rx_ready,
   // Firmware read side of the receive buffer.
   input wire logic [AW-1:0] fw_rx_addr,
   input wire logic fw_rx_done,
   output logic [7:0] fw_rx_data,
   output logic [AW:0] rx_len,
   output logic rx_full,
   output ppc_req_t req_kind,
   // Firmware write side of the transmit buffer.
   input wire logic fw_tx_we,
   input wire logic [AW-1:0] fw_tx_addr,
   input wire logic [7:0] fw_tx_wdata,
   input wire logic [AW:0] fw_tx_len,
   input wire logic fw_tx_go,
   // PD transmit path toward the host side.
   input wire logic pd_tx_ready,
   output logic pd_tx_valid,
   output logic [7:0] pd_tx_byte,
   output logic pd_tx_last,
   output logic tx_busy
);
   // Port power.

   // Power request selected from hub logic or the processor.
   wire logic [NPORT-1:0] pwr_want = cpu_mode ? cpu_pwr_req : hub_pwr_req;
   // A latched over-current keeps the port unpowered.
   wire logic [NPORT-1:0] pwr_nxt = pwr_want & ~oc_flag;
   // Raw over-current: a low on a released pin.
   wire logic [NPORT-1:0] oc_raw = port_power_sense_pin_oe_n & ~port_power_sense_pin_i;
   // Filtered over-current level per port.
   logic [NPORT-1:0] oc_filt;
   // Previous filtered level, for rising edges.
   logic [NPORT-1:0] oc_filt_d_r;
   wire logic [NPORT-1:0] oc_rise = oc_filt & ~oc_filt_d_r;

   // One filter per port ignores short lows such as power-up inrush.
   for (genvar p = 0; p < NPORT; p++) begin : g_oc
      ppc_filt u_oc (
         .mclk(mclk),
         .rst(rst),
         .d(oc_raw[p]),
         .limit(OC_LIMIT),
         .q(oc_filt[p])
      );
   end

   // Pin drive: off drives low with pull-up off, on releases with pull-up.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         port_pwr_on <= '0;
         port_power_sense_pin_o <= '0;
         port_power_sense_pin_oe_n <= '0;
         pin_pullup_en <= '0;
         programmable_function_pin <= '0;
      end else begin
         port_pwr_on <= pwr_nxt;
         port_power_sense_pin_o <= '0;
         port_power_sense_pin_oe_n <= pwr_nxt;
         pin_pullup_en <= pwr_nxt;
         programmable_function_pin <= bc_cfg & pwr_nxt;
      end
   end

   // Over-current flags: a new event wins over a clear in the same cycle.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         oc_filt_d_r <= '0;
         oc_flag <= '0;
      end else begin
         oc_filt_d_r <= oc_filt;
         oc_flag <= oc_rise | (oc_flag & ~oc_clr);
      end
   end

   // CC threshold scan.

   // Settle counter, DAC code and per-line running levels.
   logic [7:0] set_cnt_r;
   logic [DW-1:0] dac_r;
   logic [LW-1:0] acc1_r;
   logic [LW-1:0] acc2_r;
   logic [LW-1:0] lvl1_r;
   logic [LW-1:0] lvl2_r;
   logic scan_done_r;
   // One step per settle period.
   wire logic step = (set_cnt_r == 8'(SETTLE_CYC - 1));
   wire logic [LW-1:0] code_lvl = LW'(dac_r) + LW'(1);
   // Level includes the threshold being sampled now.
   wire logic [LW-1:0] new1 = cc1_cmp ? code_lvl : acc1_r;
   wire logic [LW-1:0] new2 = cc2_cmp ? code_lvl : acc2_r;
   wire logic last_step = step && (dac_r == DAC_LAST);

   // The DAC walks all eight thresholds; each sweep yields two levels.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         set_cnt_r <= '0;
         dac_r <= '0;
         acc1_r <= '0;
         acc2_r <= '0;
         lvl1_r <= LVL_ALL;
         lvl2_r <= LVL_ALL;
         scan_done_r <= 1'b0;
      end else begin
         set_cnt_r <= step ? 8'h00 : set_cnt_r + 8'h01;
         scan_done_r <= last_step;
         if (step) begin
            dac_r <= dac_r + DW'(1);
            acc1_r <= last_step ? '0 : new1;
            acc2_r <= last_step ? '0 : new2;
         end
         if (last_step) begin
            lvl1_r <= new1;
            lvl2_r <= new2;
         end
      end
   end

   // Attach decision.

   // Line classes seen by a source: Rd in the middle, Ra at the bottom.
   wire logic rd1 = (lvl1_r > LVL_RA_MAX) && (lvl1_r < LVL_OPEN);
   wire logic rd2 = (lvl2_r > LVL_RA_MAX) && (lvl2_r < LVL_OPEN);
   wire logic ra1 = (lvl1_r == LVL_RA_MAX);
   wire logic ra2 = (lvl2_r == LVL_RA_MAX);
   // Signalling line is CC2 when only CC2 shows Rd.
   wire logic orient_dfp = rd2 && !rd1;
   // Sink side: signalling line has the higher level.
   wire logic orient_ufp = (lvl2_r > lvl1_r);
   wire logic [LW-1:0] sig_lvl = orient_ufp ? lvl2_r : lvl1_r;
   // Advertised current class from the signalling level.
   wire ppc_adv_t adv_dec = (sig_lvl <= LVL_DEF_MAX) ? ADV_DEF :
                            (sig_lvl <= LVL_1A5_MAX) ? ADV_1A5 : ADV_3A0;
   // Debounced attach level.
   logic att_q;
   // Source attaches on Rd; sink follows the VBUS window.
   wire logic cand_dfp = rd1 || rd2;
   wire logic cand_ufp = vbus_monitor_safe5v || (att_q && !vbus_monitor_safe0v);
   wire logic cand = role_dfp ? cand_dfp : cand_ufp;

   // Attach candidate must hold for the programmed cycle count.
   ppc_filt u_att (
      .mclk(mclk),
      .rst(rst),
      .d(cand),
      .limit(attach_dbnc),
      .q(att_q)
   );

   // Attach state and its registers.
   ppc_att_t st_r;
   ppc_att_t st_nxt;
   logic role_r;

   // Next attach state; pending ends when the debounced level rises or the candidate drops.
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         ST_UNATT: begin
            if (cand) begin
               st_nxt = ST_PEND;
            end
         end
         ST_PEND: begin
            if (att_q) begin
               st_nxt = ST_ATT;
            end else if (!cand) begin
               st_nxt = ST_UNATT;
            end
         end
         ST_ATT: begin
            if (!att_q) begin
               st_nxt = ST_UNATT;
            end
         end
      endcase
   end

   // A role change restarts detection from unattached.
   wire logic role_chg = (role_r != role_dfp);
   wire logic entering_att = (st_r == ST_PEND) && (st_nxt == ST_ATT);
   wire logic is_att = (st_r == ST_ATT);

   // State register.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_r <= ST_UNATT;
         role_r <= 1'b0;
      end else begin
         st_r <= role_chg ? ST_UNATT : st_nxt;
         role_r <= role_dfp;
      end
   end

   // VCONN.

   // VCONN goes to the non-signalling line by default with an active cable.
   wire logic vc_on = role_dfp && is_att && tc_stat.active_cable
                      && !vconn_dis && !vconn_oc;
   wire logic [1:0] vc_nxt = vc_on ? (tc_stat.orient_cc2 ? 2'h1 : 2'h2) : 2'h0;
   // Level of the line carrying VCONN.
   wire logic [LW-1:0] vc_lvl = tc_stat.orient_cc2 ? lvl1_r : lvl2_r;
   // Check armed after one full sweep with VCONN on.
   logic vc_arm_r;
   wire logic vc_fault = vc_arm_r && scan_done_r && (vc_lvl < LVL_VCONN_MIN);

   // VCONN fault flag; a fault wins over a clear in the same cycle.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         vc_arm_r <= 1'b0;
         vconn_oc <= 1'b0;
      end else begin
         vc_arm_r <= (tc_pins.vconn_en != 2'h0) && (vc_arm_r || scan_done_r);
         vconn_oc <= vc_fault || (vconn_oc && !vconn_oc_clr);
      end
   end

   // Type-C outputs.

   // Pin controls and status, all from flip-flops.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tc_pins <= '0;
         tc_stat <= '0;
         adv_change <= 1'b0;
      end else begin
         tc_pins.rp_en <= role_dfp;
         tc_pins.rd_en <= !role_dfp;
         tc_pins.dac_code <= dac_r + (step ? DW'(1) : DW'(0));
         tc_pins.vconn_en <= vc_nxt;
         tc_stat.attached <= is_att && !role_chg;
         tc_stat.pending <= (st_r == ST_PEND) && !role_chg;
         tc_stat.dfp <= role_dfp;
         if (entering_att) begin
            tc_stat.orient_cc2 <= role_dfp ? orient_dfp : orient_ufp;
            tc_stat.active_cable <= role_dfp && (orient_dfp ? ra1 : ra2);
         end else if (!is_att) begin
            tc_stat.active_cable <= 1'b0;
         end
         if (!role_dfp && is_att) begin
            tc_stat.adv <= adv_dec;
         end else if (!is_att) begin
            tc_stat.adv <= ADV_NONE;
         end
         adv_change <= !role_dfp && is_att && scan_done_r
                       && (tc_stat.adv != ADV_NONE) && (adv_dec != tc_stat.adv);
         tc_stat.vbus_ok <= is_att && !role_chg && vbus_monitor_safe5v;
      end
   end

   // PD receive buffer.

   // Receive storage and write pointer.
   logic [7:0] rx_mem [BDEPTH];
   logic [AW:0] rx_wptr_r;
   // A byte is taken while the buffer is not holding a message.
   wire logic rx_take = pd_rx_valid && pd_rx_ready && !rx_full;
   wire logic rx_room = (rx_wptr_r < (AW+1)'(BDEPTH));
   // Request kind decoded from the first byte.
   wire ppc_req_t req_dec = (pd_rx_byte == RC_BATT) ? RQ_BATT :
                            (pd_rx_byte == RC_FEAT) ? RQ_FEAT :
                            (pd_rx_byte == RC_WREG) ? RQ_WREG :
                            (pd_rx_byte == RC_RREG) ? RQ_RREG :
                            (pd_rx_byte == RC_WMEM) ? RQ_WMEM :
                            (pd_rx_byte == RC_RMEM) ? RQ_RMEM : RQ_OTHER;
   wire logic [AW:0] rx_cnt_nxt = rx_wptr_r + ((AW+1)'(rx_room));

   // Buffer writes; excess bytes of an over-long message are dropped.
   always_ff @(posedge mclk) begin
      if (rx_take && rx_room) begin
         rx_mem[rx_wptr_r[AW-1:0]] <= pd_rx_byte;
      end
   end

   // Message framing, firmware release and read port.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rx_wptr_r <= '0;
         rx_full <= 1'b0;
         rx_len <= '0;
         req_kind <= RQ_NONE;
         fw_rx_data <= '0;
         pd_rx_ready <= 1'b0;
      end else begin
         fw_rx_data <= rx_mem[fw_rx_addr];
         pd_rx_ready <= !rx_full && !(rx_take && pd_rx_last);
         if (rx_take) begin
            rx_wptr_r <= pd_rx_last ? '0 : rx_cnt_nxt;
            if (rx_wptr_r == '0) begin
               req_kind <= req_dec;
            end
            if (pd_rx_last) begin
               rx_full <= 1'b1;
               rx_len <= rx_cnt_nxt;
            end
         end else if (fw_rx_done && rx_full) begin
            rx_full <= 1'b0;
            rx_len <= '0;
            req_kind <= RQ_NONE;
         end
      end
   end

   // PD transmit buffer.

   // Transmit storage, read index and message length.
   logic [7:0] tx_mem [BDEPTH];
   logic [AW:0] tx_idx_r;
   logic [AW:0] tx_len_r;
   // A start with a non-empty length is taken only when idle.
   wire logic tx_start = fw_tx_go && !tx_busy && (fw_tx_len != '0);
   wire logic tx_adv = pd_tx_valid && pd_tx_ready;
   wire logic [AW:0] tx_idx_nxt = tx_idx_r + (AW+1)'(1);
   wire logic tx_more = (tx_idx_nxt < tx_len_r);

   // Firmware fills the buffer.
   always_ff @(posedge mclk) begin
      if (fw_tx_we) begin
         tx_mem[fw_tx_addr] <= fw_tx_wdata;
      end
   end

   // Stream the buffered response out with valid and ready.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tx_idx_r <= '0;
         tx_len_r <= '0;
         tx_busy <= 1'b0;
         pd_tx_valid <= 1'b0;
         pd_tx_byte <= '0;
         pd_tx_last <= 1'b0;
      end else if (tx_start) begin
         tx_idx_r <= '0;
         tx_len_r <= fw_tx_len;
         tx_busy <= 1'b1;
         pd_tx_valid <= 1'b1;
         pd_tx_byte <= tx_mem[0];
         pd_tx_last <= (fw_tx_len == (AW+1)'(1));
      end else if (tx_adv) begin
         tx_idx_r <= tx_idx_nxt;
         tx_busy <= tx_more;
         pd_tx_valid <= tx_more;
         pd_tx_byte <= tx_mem[tx_idx_nxt[AW-1:0]];
         pd_tx_last <= tx_more && ((tx_idx_nxt + (AW+1)'(1)) == tx_len_r);
      end
   end
endmodule

// [tb/ppc_ext_model.sv]
// Model of the external power switch, VCONN FETs and CC line levels.
// Assumes the bench commands faults and CC levels in mclk cycles.
`timescale 1ns/1ps
module ppc_ext_model import ppc_pkg::*; (
   // Clock.
   input wire logic mclk,
   // Shared pin as split by the block.
   input wire logic [NPORT-1:0] pin_o,
   input wire logic [NPORT-1:0] pin_oe_n,
   input wire logic [NPORT-1:0] pullup_en,
   output logic [NPORT-1:0] pin_i,
   // Faults commanded by the bench.
   input wire logic [NPORT-1:0] oc_fault,
   input wire logic vconn_fault,
   // CC levels as counts of thresholds exceeded, and comparator side.
   input wire logic [LW-1:0] cc1_lvl,
   input wire logic [LW-1:0] cc2_lvl,
   input wire ppc_tc_pins_t tc_pins,
   output logic cc1_cmp,
   output logic cc2_cmp
);
   // A released line with no pull-up toggles.
   logic [NPORT-1:0] flip_r = '0;
   always_ff @(posedge mclk) flip_r <= ~flip_r;
   // The switch pulls the released sense line low while it sees over-current.
   assign pin_i = (~pin_oe_n & pin_o) | (pin_oe_n & ~oc_fault & (pullup_en | flip_r));
   // A healthy VCONN FET lifts its CC line above every threshold.
   wire [LW-1:0] lvl1 = (tc_pins.vconn_en[0] && !vconn_fault) ? LVL_ALL : cc1_lvl;
   wire [LW-1:0] lvl2 = (tc_pins.vconn_en[1] && !vconn_fault) ? LVL_ALL : cc2_lvl;
   // The comparator trips while the line sits above the selected threshold.
   assign cc1_cmp = lvl1 > {1'b0, tc_pins.dac_code};
   assign cc2_cmp = lvl2 > {1'b0, tc_pins.dac_code};
endmodule

// [tb/ppc_port_ctrl_checker.sv]
// Checker for pin control, over-current and Type-C outputs.
// Assumes it is bound to ppc_port_ctrl and sees only its ports.
`timescale 1ns/1ps
module ppc_chk import ppc_pkg::*; (
   // Clock, reset and inputs.
   input wire logic mclk,
   input wire logic rst,
   input wire logic cpu_mode,
   input wire logic [NPORT-1:0] hub_pwr_req,
   input wire logic [NPORT-1:0] cpu_pwr_req,
   input wire logic [NPORT-1:0] bc_cfg,
   input wire logic [NPORT-1:0] oc_clr,
   input wire logic [NPORT-1:0] port_power_sense_pin_i,
   // Observed outputs.
   input wire logic [NPORT-1:0] port_power_sense_pin_o,
   input wire logic [NPORT-1:0] port_power_sense_pin_oe_n,
   input wire logic [NPORT-1:0] pin_pullup_en,
   input wire logic [NPORT-1:0] programmable_function_pin,
   input wire logic [NPORT-1:0] port_pwr_on,
   input wire logic [NPORT-1:0] oc_flag,
   input wire ppc_tc_pins_t tc_pins,
   input wire ppc_tc_stat_t tc_stat,
   input wire logic adv_change,
   input wire logic vconn_oc,
   input wire logic rx_full,
   input wire logic pd_rx_ready
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Allowed power and a run length of low samples on port 0.
   wire [NPORT-1:0] sel_req = (cpu_mode ? cpu_pwr_req : hub_pwr_req) & ~oc_flag;
   wire low_seen = !port_power_sense_pin_i[0] && port_power_sense_pin_oe_n[0] && !oc_flag[0];
   logic [11:0] low_cnt_r;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) low_cnt_r <= 12'h000;
      else low_cnt_r <= low_seen ? low_cnt_r + 12'h001 : 12'h000;
   end
   a_pin_drive: assert property (
      port_power_sense_pin_o == '0 && port_power_sense_pin_oe_n == port_pwr_on)
      else $error("pin drive wrong");
   a_pullup_off: assert property (
      pin_pullup_en == port_power_sense_pin_oe_n) else $error("pull-up on while driving");
   a_power_sel: assert property (
      !$past(rst) |-> port_pwr_on == $past(sel_req)) else $error("power state wrong");
   a_oc_filter: assert property (
      $rose(oc_flag[0]) |-> low_cnt_r >= 12'h3E6) else $error("over-current flagged too soon");
   a_oc_trip: assert property (
      low_cnt_r <= 12'h3F0) else $error("over-current not flagged");
   a_oc_sticky: assert property (
      ($past(oc_flag) & ~oc_flag & ~$past(oc_clr)) == '0) else $error("flag lost");
   a_bc_only: assert property (
      (programmable_function_pin & ~$past(bc_cfg)) == '0) else $error("charger shown unasked");
   a_dac_step: assert property (
      $changed(tc_pins.dac_code) |-> tc_pins.dac_code == $past(tc_pins.dac_code) + 3'h1)
      else $error("threshold step wrong");
   a_dac_hold: assert property (
      $changed(tc_pins.dac_code) |=> $stable(tc_pins.dac_code) [*8]) else $error("settle short");
   a_vconn_cut: assert property (
      vconn_oc |=> tc_pins.vconn_en == 2'h0) else $error("VCONN on after fault");
   a_vconn_one: assert property (
      tc_pins.vconn_en != 2'h3) else $error("VCONN on both lines");
   a_vbus_ok: assert property (
      tc_stat.vbus_ok |-> tc_stat.attached) else $error("VBUS good while detached");
   a_rx_hold: assert property (
      rx_full |-> !pd_rx_ready) else $error("ready while buffer full");
   c_oc: cover property ($rose(oc_flag[0]));
   c_att: cover property ($rose(tc_stat.attached));
   c_vconn: cover property ($rose(vconn_oc));
   c_adv: cover property (adv_change);
endmodule
bind ppc_port_ctrl ppc_chk u_chk (.*);

// [tb/tb_port_power_and_typec_attach_control.sv]
// Testbench for port power, over-current, Type-C attach and PD buffers.
// Assumes the external model and the bound checker are compiled before it.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_total++; \
   $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb_port_power_and_typec_attach_control import ppc_pkg::*;;
   logic mclk = 1'b0, rst = 1'b1, cpu_mode = 1'b0, role_dfp = 1'b0, vconn_dis = 1'b0;
   logic vbus_monitor_safe5v = 1'b0, vconn_oc_clr = 1'b0;
   wire vbus_monitor_safe0v = !vbus_monitor_safe5v;
   logic [NPORT-1:0] hub_pwr_req = '0, cpu_pwr_req = '0, bc_cfg = '0, oc_clr = '0, oc_fault = '0;
   logic [NPORT-1:0] port_power_sense_pin_i, port_power_sense_pin_o, port_power_sense_pin_oe_n;
   logic [NPORT-1:0] pin_pullup_en, programmable_function_pin, port_pwr_on, oc_flag;
   logic cc1_cmp, cc2_cmp, adv_change, vconn_oc, vconn_fault = 1'b0;
   logic [LW-1:0] cc1_lvl = LVL_OPEN, cc2_lvl = LVL_OPEN;
   logic [FW-1:0] attach_dbnc = 12'h010;
   ppc_tc_pins_t tc_pins;
   ppc_tc_stat_t tc_stat;
   logic pd_rx_valid = 1'b0, pd_rx_last = 1'b0, fw_rx_done = 1'b0, pd_rx_ready, rx_full;
   logic [7:0] pd_rx_byte = '0, fw_tx_wdata = '0, fw_rx_data, pd_tx_byte;
   logic [AW-1:0] fw_rx_addr = '0, fw_tx_addr = '0;
   logic [AW:0] fw_tx_len = '0, rx_len;
   ppc_req_t req_kind;
   logic fw_tx_we = 1'b0, fw_tx_go = 1'b0, pd_tx_ready = 1'b0, pd_tx_valid, pd_tx_last, tx_busy;
   int err_total = 0, checks = 0, seen;
   logic [7:0] codes [7] = '{RC_BATT, RC_FEAT, RC_WREG, RC_RREG, RC_WMEM, RC_RMEM, 8'h77};
   ppc_req_t kinds [7] = '{RQ_BATT, RQ_FEAT, RQ_WREG, RQ_RREG, RQ_WMEM, RQ_RMEM, RQ_OTHER};
   ppc_port_ctrl uut (.*);
   ppc_ext_model ext_sw (.mclk, .pin_o(port_power_sense_pin_o),
      .pin_oe_n(port_power_sense_pin_oe_n), .pullup_en(pin_pullup_en),
      .pin_i(port_power_sense_pin_i), .oc_fault, .vconn_fault, .cc1_lvl, .cc2_lvl, .tc_pins,
      .cc1_cmp, .cc2_cmp);
   // The 10 MHz clock.
   initial forever #50 mclk = ~mclk;
   // Steps whole cycles, ending on a falling edge.
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // Sends a two-byte message, checks its length, kind and second byte, and releases the buffer.
   task automatic rx_msg(input logic [7:0] code, input ppc_req_t kind);
      for (int i = 0; i < 2; i++) begin
         `CHK(pd_rx_ready, 1'b1)
         pd_rx_valid = 1'b1;
         pd_rx_byte = (i == 0) ? code : 8'hA5;
         pd_rx_last = (i == 1);
         cyc(1);
      end
      pd_rx_valid = 1'b0;
      pd_rx_last = 1'b0;
      fw_rx_addr = 4'h1;
      cyc(2);
      `CHK(rx_full, 1'b1)
      `CHK(rx_len, 5'h02)
      `CHK(req_kind, kind)
      `CHK(fw_rx_data, 8'hA5)
      fw_rx_done = 1'b1;
      cyc(1);
      fw_rx_done = 1'b0;
      repeat (4) if (pd_rx_ready !== 1'b1) cyc(1);
   endtask
   // Prints the verdict and stops.
   task automatic complete_run();
      if (err_total == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // A hang is cut short well beyond the expected run time.
   initial begin
      #2_000_000;
      err_total++;
      complete_run();
   end
   // Main sequence.
   initial begin
      cyc(20);
      rst = 1'b0;
      cyc(2);
      `CHK(port_power_sense_pin_oe_n, 4'h0)
      `CHK(port_power_sense_pin_o, 4'h0)
      `CHK(pin_pullup_en, 4'h0)
      hub_pwr_req = 4'h5;
      cpu_pwr_req = 4'hA;
      cyc(2);
      `CHK(port_power_sense_pin_oe_n, 4'h5)
      `CHK(pin_pullup_en, 4'h5)
      cpu_mode = 1'b1;
      bc_cfg = 4'h3;
      cyc(3);
      `CHK(port_pwr_on, 4'hA)
      `CHK(programmable_function_pin, 4'h2)
      cpu_mode = 1'b0;
      hub_pwr_req = 4'hF;
      cyc(3);
      oc_fault = 4'h1;
      cyc(500);
      oc_fault = 4'h0;
      cyc(1100);
      `CHK(oc_flag, 4'h0)
      oc_fault = 4'h1;
      cyc(1100);
      `CHK(oc_flag, 4'h1)
      `CHK(port_power_sense_pin_oe_n, 4'hE)
      oc_fault = 4'h0;
      cyc(1100);
      `CHK(oc_flag, 4'h1)
      oc_clr = 4'h1;
      cyc(1);
      oc_clr = 4'h0;
      cyc(3);
      `CHK(oc_flag, 4'h0)
      `CHK(port_pwr_on, 4'hF)
      for (int k = 0; k < 7; k++) rx_msg(codes[k], kinds[k]);
      fw_tx_we = 1'b1;
      for (int i = 0; i < 2; i++) begin
         fw_tx_addr = AW'(i);
         fw_tx_wdata = 8'h3C + 8'(i);
         cyc(1);
      end
      fw_tx_we = 1'b0;
      fw_tx_len = 5'h02;
      fw_tx_go = 1'b1;
      cyc(1);
      fw_tx_go = 1'b0;
      cyc(3);
      `CHK(tx_busy, 1'b1)
      for (int i = 0; i < 2; i++) begin
         `CHK(pd_tx_valid, 1'b1)
         `CHK(pd_tx_byte, 8'h3C + 8'(i))
         `CHK(pd_tx_last, (i == 1))
         pd_tx_ready = 1'b1;
         cyc(1);
      end
      pd_tx_ready = 1'b0;
      cyc(1);
      `CHK(pd_tx_valid, 1'b0)
      cc1_lvl = 4'h3;
      cc2_lvl = 4'h0;
      vbus_monitor_safe5v = 1'b1;
      cyc(6);
      `CHK(tc_stat.attached, 1'b0)
      `CHK(tc_stat.pending, 1'b1)
      cyc(200);
      `CHK(tc_stat.attached, 1'b1)
      `CHK(tc_pins.rd_en, 1'b1)
      `CHK(tc_stat.adv, ADV_1A5)
      cc1_lvl = 4'h5;
      seen = 0;
      repeat (200) begin
         cyc(1);
         if (adv_change === 1'b1) seen++;
      end
      `CHK(seen, 1)
      `CHK(tc_stat.adv, ADV_3A0)
      vbus_monitor_safe5v = 1'b0;
      cyc(40);
      `CHK(tc_stat.attached, 1'b0)
      role_dfp = 1'b1;
      cc1_lvl = 4'h3;
      cc2_lvl = LVL_RA_MAX;
      cyc(250);
      `CHK(tc_stat.attached, 1'b1)
      `CHK(tc_pins.rp_en, 1'b1)
      `CHK(tc_stat.active_cable, 1'b1)
      `CHK(tc_pins.vconn_en, 2'h2)
      vbus_monitor_safe5v = 1'b1;
      cyc(3);
      `CHK(tc_stat.vbus_ok, 1'b1)
      vconn_fault = 1'b1;
      cyc(200);
      `CHK(vconn_oc, 1'b1)
      `CHK(tc_pins.vconn_en, 2'h0)
      vconn_fault = 1'b0;
      vconn_oc_clr = 1'b1;
      cyc(1);
      vconn_oc_clr = 1'b0;
      cyc(200);
      `CHK(vconn_oc, 1'b0)
      complete_run();
   end
endmodule
